//--- hdl/pcd_pkg.sv
// constants shared by the pin change detector and its helpers
// assumes a 32-bit avalon-mm register bus with byte addresses
package pcd_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [5:0] PCD_OFS_A_ENABLE = 6'h00;
    localparam logic [5:0] PCD_OFS_B_ENABLE = 6'h04;
    localparam logic [5:0] PCD_OFS_CONTROL  = 6'h08;
    localparam logic [5:0] PCD_OFS_A_DATA   = 6'h0C;
    localparam logic [5:0] PCD_OFS_B_DATA   = 6'h10;
    localparam logic [5:0] PCD_OFS_IRQ_STAT = 6'h14;
    localparam logic [5:0] PCD_OFS_IRQ_MASK = 6'h18;

    // ****************************************
    // implemented bits and reset values
    // ****************************************
    localparam logic [7:0] PCD_A_IMPL_MASK  = 8'hEF;
    localparam logic [7:0] PCD_B_IMPL_MASK  = 8'hF3;
    localparam logic [7:0] PCD_ENABLE_RESET = 8'h00;
    localparam logic [1:0] PCD_IRQ_RESET    = 2'h0;
    localparam int         PCD_RESET_PIN    = 5;

    // control register fields
    localparam int PCD_CTL_INT_EN = 0;
    localparam int PCD_CTL_FLAG   = 1;

    // interrupt status fields
    localparam int PCD_IRQ_FLAG_SET = 0;
    localparam int PCD_IRQ_WAKE     = 1;

    // bus answer state
    typedef enum logic [0:0] {
        PCD_BUS_IDLE = 1'b0,
        PCD_BUS_DONE = 1'b1
    } pcd_bus_type;
endpackage : pcd_pkg

//--- hdl/pcd_sync.sv
// two flip-flop synchroniser for a bus of pin levels
// assumes the pins are asynchronous to sys_clk
module pcd_sync
    import pcd_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // pin levels
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            pin_sync   <= '0;
        end else begin
            stage1_reg <= pin_async;
            pin_sync   <= stage1_reg;
        end
    end
endmodule : pcd_sync

//--- hdl/pcd_port_cmp.sv
// per-port last-read latch and mismatch compare
// assumes pin levels already synchronised to sys_clk
module pcd_port_cmp
    import pcd_pkg::*;
(
    // clock and power-on reset only; the latch ignores other resets
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    // pins and qualifiers
    input  wire logic [7:0] pin_level,
    input  wire logic [7:0] pin_enable,
    input  wire logic       port_access,
    // results
    output logic      [7:0] last_read,
    output logic            mismatch
);
    // latch captures the live level on any read or write of the port
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            last_read <= 8'h00;
        end else if (port_access) begin
            last_read <= pin_level;
        end
    end

    // the access cycle masks the compare, so a change then may be missed
    always_comb begin
        mismatch = |((pin_level ^ last_read) & pin_enable) & ~port_access;
    end
endmodule : pcd_port_cmp

//--- hdl/pcd_detector.sv
// pin change detector for two 8-bit general purpose ports
// assumes avalon-mm master on sys_clk; pins asynchronous; ext_reset synchronous
//
// What this block does
// - every pin except port a pin 4 and port b pins 3..2 has its own change-detection enable bit
// - power-on reset clears all per-pin enable bits
// - port a pin 5 never detects changes while it is the reset input
// - enabled pins compare live level with latch taken at last port read or write
// - mismatches of all enabled pins are ored into one shared change flag
// - with interrupt enable clear the flag still sets but pin_change_irq stays low
// - a lasting mismatch keeps setting the flag despite software clears
// - latch survives external reset; flag sets again after it on mismatch
// - a change in the cycle of a port access may be missed
// - a change wakes the device from sleep only with interrupt enable set
// - port a enable bits 7..5 and 3..0; bit 4 reads zero
// - port b enable bits 7..4 and 1..0; bits 3..2 read zero
// - enable bit one turns detection on, zero turns it off
// - a pin selected as analog input never detects changes
module pcd_detector
    import pcd_pkg::*;
(
    // clock and resets
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        ext_reset,
    // avalon-mm slave
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // port pins
    input  wire logic [7:0]  port_a_pin,
    input  wire logic [7:0]  port_b_pin,
    // configuration from the rest of the device
    input  wire logic        cfg_pin5_is_reset,
    input  wire logic [7:0]  analog_sel_a,
    input  wire logic [7:0]  analog_sel_b,
    input  wire logic        sleep_mode,
    // requests to the core
    output logic             pin_change_irq,
    output logic             wake_req,
    output logic             irq
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0]  port_a_change_enable_reg;
    logic [7:0]  port_b_change_enable_reg;
    logic        pin_change_int_enable_reg;
    logic        pin_change_flag_reg;
    logic [1:0]  irq_status_reg;
    logic [1:0]  irq_mask_reg;
    logic [1:0]  rd_snap_reg;
    pcd_bus_type bus_state_reg;
    pcd_bus_type bus_state_next;

    logic [7:0]  pin_a_sync;
    logic [7:0]  pin_b_sync;
    logic [7:0]  last_a;
    logic [7:0]  last_b;
    logic        mismatch_a;
    logic        mismatch_b;
    logic [7:0]  live_en_a;
    logic [7:0]  live_en_b;

    logic        request;
    logic        accept;
    logic        wr_low;
    logic        any_change;
    logic        flag_rise;
    logic        wake_event;
    logic        access_a;
    logic        access_b;
    logic [31:0] read_word;

    logic        wr_a_enable;
    logic        wr_b_enable;
    logic        wr_control;
    logic        wr_irq_mask;
    logic        rd_irq_stat;

    // ****************************************
    // pin synchronisers
    // ****************************************
    pcd_sync #(
        .WIDTH     (8)
    ) u_sync_a (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .pin_async (port_a_pin),
        .pin_sync  (pin_a_sync)
    );

    pcd_sync #(
        .WIDTH     (8)
    ) u_sync_b (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .pin_async (port_b_pin),
        .pin_sync  (pin_b_sync)
    );

    // ****************************************
    // bus handshake
    // ****************************************
    // one wait cycle: readdata is loaded, then waitrequest drops for one cycle
    assign request = read | write;
    assign accept  = request & (bus_state_reg == PCD_BUS_DONE);
    assign wr_low  = write & byteenable[0] & (bus_state_reg == PCD_BUS_DONE);

    // answer state, a single step per request
    always_comb begin
        bus_state_next = PCD_BUS_IDLE;
        unique case (bus_state_reg)
            PCD_BUS_IDLE: begin
                if (request) begin
                    bus_state_next = PCD_BUS_DONE;
                end
            end
            PCD_BUS_DONE: begin
                bus_state_next = PCD_BUS_IDLE;
            end
        endcase
    end

    // answer state advances on every edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bus_state_reg <= PCD_BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // waitrequest drops in the cycle after a request is first seen
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= ~(request & (bus_state_reg == PCD_BUS_IDLE));
        end
    end

    // port accesses end the mismatch when the bus takes them
    assign access_a = accept & (address == PCD_OFS_A_DATA);
    assign access_b = accept & (address == PCD_OFS_B_DATA);

    // ****************************************
    // register strobes
    // ****************************************
    // one strobe per register keeps every update block to a single condition
    assign wr_a_enable = wr_low & (address == PCD_OFS_A_ENABLE);
    assign wr_b_enable = wr_low & (address == PCD_OFS_B_ENABLE);
    assign wr_control  = wr_low & (address == PCD_OFS_CONTROL);
    assign wr_irq_mask = wr_low & (address == PCD_OFS_IRQ_MASK);
    assign rd_irq_stat = read & accept & (address == PCD_OFS_IRQ_STAT);

    // ****************************************
    // per-pin enables
    // ****************************************
    // bit 4 of port a is not stored and reads as zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            port_a_change_enable_reg <= PCD_ENABLE_RESET;
        end else if (ext_reset) begin
            port_a_change_enable_reg <= PCD_ENABLE_RESET;
        end else if (wr_a_enable) begin
            port_a_change_enable_reg <= writedata[7:0] & PCD_A_IMPL_MASK;
        end
    end

    // bits 3..2 of port b are not stored and read as zero
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            port_b_change_enable_reg <= PCD_ENABLE_RESET;
        end else if (ext_reset) begin
            port_b_change_enable_reg <= PCD_ENABLE_RESET;
        end else if (wr_b_enable) begin
            port_b_change_enable_reg <= writedata[7:0] & PCD_B_IMPL_MASK;
        end
    end

    // effective enables: a one turns detection on unless analog or reset pin
    always_comb begin
        live_en_a = port_a_change_enable_reg & ~analog_sel_a;
        live_en_b = port_b_change_enable_reg & ~analog_sel_b;
        if (cfg_pin5_is_reset) begin
            live_en_a[PCD_RESET_PIN] = 1'b0;
        end
    end

    // ****************************************
    // compare units
    // ****************************************
    // latches see only the power-on reset, so they ride through ext_reset
    pcd_port_cmp u_cmp_a (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .pin_level   (pin_a_sync),
        .pin_enable  (live_en_a),
        .port_access (access_a),
        .last_read   (last_a),
        .mismatch    (mismatch_a)
    );

    pcd_port_cmp u_cmp_b (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .pin_level   (pin_b_sync),
        .pin_enable  (live_en_b),
        .port_access (access_b),
        .last_read   (last_b),
        .mismatch    (mismatch_b)
    );

    // one shared flag, so software cannot tell which port moved
    assign any_change = mismatch_a | mismatch_b;

    // ****************************************
    // control: interrupt enable and change flag
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_change_int_enable_reg <= 1'b0;
        end else if (ext_reset) begin
            pin_change_int_enable_reg <= 1'b0;
        end else if (wr_control) begin
            pin_change_int_enable_reg <= writedata[PCD_CTL_INT_EN];
        end
    end

    // flag: hardware set wins over a software clear in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_change_flag_reg <= 1'b0;
        end else if (any_change) begin
            pin_change_flag_reg <= 1'b1;
        end else if (ext_reset) begin
            pin_change_flag_reg <= 1'b0;
        end else if (wr_control && !writedata[PCD_CTL_FLAG]) begin
            pin_change_flag_reg <= 1'b0;
        end
    end

    // ****************************************
    // requests toward the core
    // ****************************************
    // flag still sets with enable clear; only the request is held back
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_change_irq <= 1'b0;
        end else begin
            pin_change_irq <= (any_change | pin_change_flag_reg)
                              & pin_change_int_enable_reg;
        end
    end

    // wake also looks at the live mismatch, so it need not wait for the flag
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= sleep_mode & pin_change_int_enable_reg
                        & (any_change | pin_change_flag_reg);
        end
    end

    // ****************************************
    // event status, mask and interrupt line
    // ****************************************
    // status events: a fresh rise of the flag, and a change seen while asleep
    assign flag_rise  = any_change & ~pin_change_flag_reg;
    assign wake_event = sleep_mode & pin_change_int_enable_reg & any_change;

    // a read clears only the bits it reported; new events win over it
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status_reg <= PCD_IRQ_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg
                               & ~(rd_irq_stat ?
                                   rd_snap_reg : 2'h0))
                              | {wake_event, flag_rise};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_reg <= PCD_IRQ_RESET;
        end else if (wr_irq_mask) begin
            irq_mask_reg <= writedata[1:0];
        end
    end

    // level line, one cycle behind the status it reflects
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // unmapped offsets read as zero and ignore writes
    always_comb begin
        read_word = 32'h0000_0000;
        unique case (address)
            PCD_OFS_A_ENABLE: read_word[7:0] = port_a_change_enable_reg;
            PCD_OFS_B_ENABLE: read_word[7:0] = port_b_change_enable_reg;
            PCD_OFS_CONTROL: begin
                read_word[PCD_CTL_INT_EN] = pin_change_int_enable_reg;
                read_word[PCD_CTL_FLAG]   = pin_change_flag_reg;
            end
            PCD_OFS_A_DATA:   read_word[7:0] = pin_a_sync;
            PCD_OFS_B_DATA:   read_word[7:0] = pin_b_sync;
            PCD_OFS_IRQ_STAT: read_word[1:0] = irq_status_reg;
            PCD_OFS_IRQ_MASK: read_word[1:0] = irq_mask_reg;
            default:          read_word = 32'h0000_0000;
        endcase
    end

    // data is loaded in the wait cycle and stands through the accept edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && bus_state_reg == PCD_BUS_IDLE) begin
            readdata <= read_word;
        end
    end

    // snapshot taken with the data, so a status read clears only what it reported
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_snap_reg <= 2'h0;
        end else if (read && bus_state_reg == PCD_BUS_IDLE) begin
            rd_snap_reg <= irq_status_reg;
        end
    end
endmodule : pcd_detector

//--- verification/pcd_detector_assertions.sv
// checker for the pin change detector, attached by bind from the bench
// assumes one sys_clk domain and nrst as its power-on reset
module pcd_detector_chk
    import pcd_pkg::*;
(
    // clock and resets
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        ext_reset,
    // register bus
    input wire logic [5:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // sleep and requests
    input wire logic        sleep_mode,
    input wire logic        pin_change_irq,
    input wire logic        wake_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // bus handshake
    // ****************************************
    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered one cycle later");
    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("accept lasted more than one cycle");
    idle_wait_a: assert property (!(read || write) |-> waitrequest)
        else $error("accept without a request");
    unmapped_zero_a: assert property (read && !waitrequest && address >= 6'h1C
        |-> readdata == 32'h0) else $error("unmapped place read nonzero");
    // ****************************************
    // enable registers and requests
    // ****************************************
    a_unimpl_a: assert property (read && !waitrequest && address == PCD_OFS_A_ENABLE
        |-> readdata[4] == 1'b0 && readdata[31:8] == 24'h0) else $error("port a bit 4 set");
    b_unimpl_a: assert property (read && !waitrequest && address == PCD_OFS_B_ENABLE
        |-> readdata[3:2] == 2'b00 && readdata[31:8] == 24'h0) else $error("port b bits set");
    wake_sleep_a: assert property (wake_req == ($past(sleep_mode) && pin_change_irq))
        else $error("wake request without sleep and change request");
    // the module enable is gone one edge after the reset; the request one more
    ext_clear_a: assert property (ext_reset |-> ##2 !pin_change_irq)
        else $error("change request survived external reset");
    cover property (wake_req);
    cover property (pin_change_irq ##1 !pin_change_irq);
    cover property (read && !waitrequest && address == PCD_OFS_IRQ_STAT);
endmodule : pcd_detector_chk

//--- verification/pcd_pin_model.sv
// stand-in for the external pins of both ports
// assumes the bench sets wanted levels; pins lag them, unrelated to sys_clk
module pcd_pin_model
    import pcd_pkg::*;
(
    // wanted levels
    input  wire logic [7:0] want_a,
    input  wire logic [7:0] want_b,
    // pins toward the detector
    output logic      [7:0] port_a_pin,
    output logic      [7:0] port_b_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins start low, so the compare never sees an unknown level before the first change
    initial begin
        port_a_pin = 8'h00;
        port_b_pin = 8'h00;
    end
    // 7 ns lag keeps pin edges away from the sampling edge
    always @(want_a) port_a_pin <= #7 want_a;
    always @(want_b) port_b_pin <= #7 want_b;
endmodule : pcd_pin_model

//--- verification/port_pin_change_detector_test.sv
// bench for the pin change detector: bus tasks, pin model, read notes
// assumes pcd_pkg, the design, checker and pin model compiled before it
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module port_pin_change_detector_test
    import pcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, nrst = 1'b0, ext_reset = 1'b0, sleep_mode = 1'b0;
    logic        read = 1'b0, write = 1'b0, cfg_pin5_is_reset = 1'b0;
    logic [5:0]  address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, e;
    logic [3:0]  byteenable = 4'hF;
    logic [7:0]  want_a = 8'h00, want_b = 8'h00, analog_sel_a = 8'h00, analog_sel_b = 8'h00;
    logic [7:0]  port_a_pin, port_b_pin, r;
    logic        waitrequest, pin_change_irq, wake_req, irq;
    int          miscompares = 0, tests_run = 0, cycles = 0, seed = 5;
    logic [31:0] exp_q[$];

    always #12.5 sys_clk = ~sys_clk;

    pcd_detector dut (.sys_clk(sys_clk), .nrst(nrst), .ext_reset(ext_reset),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .port_a_pin(port_a_pin), .port_b_pin(port_b_pin),
        .cfg_pin5_is_reset(cfg_pin5_is_reset), .analog_sel_a(analog_sel_a),
        .analog_sel_b(analog_sel_b), .sleep_mode(sleep_mode),
        .pin_change_irq(pin_change_irq), .wake_req(wake_req), .irq(irq));
    pcd_pin_model pins (.want_a(want_a), .want_b(want_b),
        .port_a_pin(port_a_pin), .port_b_pin(port_b_pin));

    // ****************************************
    // bus tasks
    // ****************************************
    // request held until waitrequest is seen low; one idle edge after release
    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        address   <= a;
        writedata <= {24'h0, d};
        write     <= w;
        read      <= ~w;
        do @(posedge sys_clk); while (waitrequest !== 1'b0);
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        exp_q.push_back({24'h0, x});
        bus(1'b0, a, 8'h00);
    endtask : rd
    // enough for two sync flops, the flag and the delayed requests
    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask : settle
    task automatic pulse_ext();
        ext_reset <= 1'b1;
        @(posedge sys_clk);
        ext_reset <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse_ext
    task automatic end_of_test();
        $display("comparisons %0d, miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // each accepted read is matched with the oldest note
    always @(posedge sys_clk) begin
        if (read && waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            `CHK(readdata, e)
        end
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(PCD_OFS_A_ENABLE, 8'h00);
        rd(PCD_OFS_B_ENABLE, 8'h00);
        rd(PCD_OFS_CONTROL, 8'h00);
        rd(PCD_OFS_IRQ_MASK, 8'h00);
        // random enables; unimplemented bits read back zero
        repeat (4) begin
            r = 8'($random(seed));
            wr(PCD_OFS_A_ENABLE, r);
            rd(PCD_OFS_A_ENABLE, r & PCD_A_IMPL_MASK);
            wr(PCD_OFS_B_ENABLE, ~r);
            rd(PCD_OFS_B_ENABLE, ~r & PCD_B_IMPL_MASK);
        end
        // lane 0 off drops the write; unmapped place reads zero
        byteenable <= 4'h0;
        wr(PCD_OFS_A_ENABLE, 8'hFF);
        byteenable <= 4'hF;
        rd(PCD_OFS_A_ENABLE, r & PCD_A_IMPL_MASK);
        wr(6'h20, 8'h5A);
        rd(6'h20, 8'h00);
        // disabled pin is ignored; enabled pin sets the flag, no request
        wr(PCD_OFS_A_ENABLE, 8'h01);
        wr(PCD_OFS_B_ENABLE, 8'h00);
        wr(PCD_OFS_IRQ_MASK, 8'h01);
        want_b <= 8'h01;
        settle();
        rd(PCD_OFS_CONTROL, 8'h00);
        want_a <= 8'h01;
        settle();
        rd(PCD_OFS_CONTROL, 8'h02);
        `CHK(pin_change_irq, 1'b0)
        `CHK(irq, 1'b1)
        rd(PCD_OFS_IRQ_STAT, 8'h01);
        settle();
        `CHK(irq, 1'b0)
        // clear without a port access cannot stick
        wr(PCD_OFS_CONTROL, 8'h01);
        rd(PCD_OFS_CONTROL, 8'h03);
        `CHK(pin_change_irq, 1'b1)
        sleep_mode <= 1'b1;
        settle();
        `CHK(wake_req, 1'b1)
        wr(PCD_OFS_CONTROL, 8'h00);
        settle();
        `CHK(wake_req, 1'b0)
        `CHK(pin_change_irq, 1'b0)
        sleep_mode <= 1'b0;
        // service order: port read first, then flag clear
        rd(PCD_OFS_A_DATA, 8'h01);
        wr(PCD_OFS_CONTROL, 8'h01);
        rd(PCD_OFS_CONTROL, 8'h01);
        // reset-pin and analog pins are blind; masked status keeps irq low
        wr(PCD_OFS_A_ENABLE, 8'hEF);
        wr(PCD_OFS_IRQ_MASK, 8'h00);
        cfg_pin5_is_reset <= 1'b1;
        analog_sel_a <= 8'h02;
        want_a <= 8'h23;
        settle();
        rd(PCD_OFS_CONTROL, 8'h01);
        cfg_pin5_is_reset <= 1'b0;
        settle();
        rd(PCD_OFS_CONTROL, 8'h03);
        `CHK(irq, 1'b0)
        rd(PCD_OFS_IRQ_STAT, 8'h03);
        analog_sel_a <= 8'h00;
        rd(PCD_OFS_A_DATA, 8'h23);
        wr(PCD_OFS_CONTROL, 8'h00);
        // external reset: latch kept, flag comes back on a mismatch
        pulse_ext();
        rd(PCD_OFS_A_ENABLE, 8'h00);
        wr(PCD_OFS_A_ENABLE, 8'hEF);
        settle();
        rd(PCD_OFS_CONTROL, 8'h00);
        want_a <= 8'h22;
        settle();
        rd(PCD_OFS_CONTROL, 8'h02);
        pulse_ext();
        rd(PCD_OFS_CONTROL, 8'h02);
        // port b feeds the same flag; a port write ends its mismatch
        wr(PCD_OFS_CONTROL, 8'h00);
        wr(PCD_OFS_B_ENABLE, 8'h01);
        settle();
        rd(PCD_OFS_CONTROL, 8'h02);
        wr(PCD_OFS_B_DATA, 8'h00);
        wr(PCD_OFS_CONTROL, 8'h00);
        rd(PCD_OFS_CONTROL, 8'h00);
        end_of_test();
    end
endmodule : port_pin_change_detector_test

bind pcd_detector pcd_detector_chk chk (.sys_clk(sys_clk), .nrst(nrst),
    .ext_reset(ext_reset), .address(address), .read(read), .write(write),
    .readdata(readdata), .waitrequest(waitrequest), .sleep_mode(sleep_mode),
    .pin_change_irq(pin_change_irq), .wake_req(wake_req));
